/* File: ocfr_pkg.sv */
package ocfr_pkg;
  // register location and field layout
  localparam logic [7:0] OCFR_REG_OFFSET = 8'h47;
  localparam logic [7:0] OCFR_REG_RESET = 8'h00;
  localparam int OCFR_RESP_HI = 7;
  localparam int OCFR_RESP_LO = 6;
  localparam int OCFR_RETRY_HI = 5;
  localparam int OCFR_RETRY_LO = 3;
  localparam int OCFR_DELAY_HI = 2;
  localparam int OCFR_DELAY_LO = 0;
  // response codes
  localparam logic [1:0] OCFR_RESP_IGNORE = 2'h0;
  localparam logic [1:0] OCFR_RESP_COND = 2'h1;
  localparam logic [1:0] OCFR_RESP_DELAY = 2'h2;
  localparam logic [1:0] OCFR_RESP_OFF = 2'h3;
  // retry counts
  localparam logic [2:0] OCFR_RETRY_NONE = 3'h0;
  localparam logic [2:0] OCFR_RETRY_FOREVER = 3'h7;
  // width of the delay unit counter
  localparam int OCFR_CNT_W = 16;
  localparam int OCFR_MULT_W = 8;
  // controller states
  typedef enum logic [2:0] {
    OCFR_RUN, OCFR_LIMIT, OCFR_WAIT, OCFR_START, OCFR_LATCH
  } ocfr_state_e;
endpackage : ocfr_pkg

/* File: ocfr_unit_timer.sv */
`timescale 1ns/100ps
// counts a number of delay units; each unit is a number of clock cycles
module ocfr_unit_timer
  import ocfr_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic start_i,
  input wire logic [OCFR_CNT_W-1:0] unit_cycles_i,
  input wire logic [OCFR_MULT_W-1:0] units_i,
  output logic done_o
);
  logic [OCFR_CNT_W-1:0] cyc;
  logic [OCFR_MULT_W-1:0] left;
  logic busy;
  wire unit_tick = busy && (cyc <= 16'h0001);

  // unit divider and unit countdown
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cyc <= '0;
      left <= '0;
      busy <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cyc <= unit_cycles_i;
        left <= units_i;
        busy <= 1'b1;
      end else if (unit_tick) begin
        cyc <= unit_cycles_i;
        left <= left - 8'h01;
        if (left <= 8'h01) begin
          busy <= 1'b0;
          done_o <= 1'b1;
        end
      end else if (busy) begin
        cyc <= cyc - 16'h0001;
      end
    end
  end
endmodule : ocfr_unit_timer

/* File: ocfr_fault_response.sv */
`timescale 1ns/100ps
// Function
// - every overcurrent sets status fault bit
// - every overcurrent notifies the host
// - code 00 limits current forever
// - code 01 limits while voltage above floor
// - code 01 below floor shuts down, retries
// - code 10 limits for delay, then retries
// - code 11 shuts down at once, retries
// - bits 5:3 give restart attempt count
// - count 000 stays off until cleared
// - count 111 retries without limit
// - count 001 gives one attempt then off
// - attempt spacing is 2 to the power of the delay field, in units
// - delay field selects 1 to 128 units
// - counts 2 to 6 then off
// - endless retry stops on off/bias/fault
module ocfr_fault_response (
  input wire logic clk_sys_i,
  input wire logic nrst_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [ocfr_pkg::OCFR_CNT_W-1:0] unit_cycles_i,
  input wire logic oc_det_i,
  input wire logic lv_det_i,
  input wire logic run_cmd_i,
  input wire logic bias_ok_i,
  input wire logic other_fault_i,
  input wire logic fault_clear_i,
  output logic output_en_o,
  output logic current_limit_o,
  output logic oc_fault_status_o,
  output logic host_notify_o,
  output logic latched_off_o
);
  import ocfr_pkg::*;

  logic [7:0] setting;
  ocfr_state_e state;
  ocfr_state_e next_state;
  logic [2:0] tries;
  logic [1:0] oc_sync, lv_sync, run_sync, bias_sync, oth_sync;
  logic oc_prev;

  // delay field code to unit multiplier
  function automatic logic [OCFR_MULT_W-1:0] units_of(input logic [2:0] c);
    units_of = OCFR_MULT_W'(8'h01 << c);
  endfunction : units_of

  // pin inputs pass two flip-flops
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      oc_sync <= '0;
      lv_sync <= '0;
      run_sync <= '0;
      bias_sync <= '0;
      oth_sync <= '0;
      oc_prev <= 1'b0;
    end else begin
      oc_sync <= {oc_sync[0], oc_det_i};
      lv_sync <= {lv_sync[0], lv_det_i};
      run_sync <= {run_sync[0], run_cmd_i};
      bias_sync <= {bias_sync[0], bias_ok_i};
      oth_sync <= {oth_sync[0], other_fault_i};
      oc_prev <= oc_sync[1];
    end
  end

  // decoded fields and conditions
  wire oc = oc_sync[1];
  wire lv = lv_sync[1];
  wire oc_rise = oc && !oc_prev;
  wire stop_all = !run_sync[1] || !bias_sync[1] || oth_sync[1];
  wire [1:0] resp = setting[OCFR_RESP_HI:OCFR_RESP_LO];
  wire [2:0] retry = setting[OCFR_RETRY_HI:OCFR_RETRY_LO];
  wire [2:0] dly = setting[OCFR_DELAY_HI:OCFR_DELAY_LO];
  wire reg_hit = reg_wr_i && (reg_addr_i == OCFR_REG_OFFSET);
  wire more_tries = (retry == OCFR_RETRY_FOREVER) || (tries < retry);
  wire timer_start = (state == OCFR_RUN || state == OCFR_START) &&
                     next_state == OCFR_WAIT ||
                     (state == OCFR_RUN && next_state == OCFR_LIMIT &&
                      resp == OCFR_RESP_DELAY);
  wire timer_done;

  ocfr_unit_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i),
    .start_i(timer_start),
    .unit_cycles_i(unit_cycles_i),
    .units_i(units_of(dly)),
    .done_o(timer_done)
  );

  // response state choice
  always_comb begin
    next_state = state;
    case (state)
      OCFR_RUN: begin
        if (oc) begin
          if (resp == OCFR_RESP_OFF) begin
            next_state = OCFR_START;
          end else begin
            next_state = OCFR_LIMIT;
          end
        end
      end
      OCFR_LIMIT: begin
        if (!oc) begin
          next_state = OCFR_RUN;
        end else if (resp == OCFR_RESP_COND && lv) begin
          next_state = OCFR_START;
        end else if (resp == OCFR_RESP_DELAY && timer_done) begin
          next_state = OCFR_START;
        end else if (resp == OCFR_RESP_OFF) begin
          next_state = OCFR_START;
        end
      end
      OCFR_START: begin
        // shutdown point: decide on another attempt
        if (more_tries && !stop_all) begin
          next_state = OCFR_WAIT;
        end else begin
          next_state = OCFR_LATCH;
        end
      end
      OCFR_WAIT: begin
        if (stop_all) begin
          next_state = OCFR_LATCH;
        end else if (timer_done) begin
          next_state = OCFR_RUN;
        end
      end
      OCFR_LATCH: begin
        if (fault_clear_i) begin
          next_state = OCFR_RUN;
        end
      end
      default: next_state = OCFR_RUN;
    endcase
  end

  // state, setting and attempt count
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= OCFR_RUN;
      setting <= OCFR_REG_RESET;
      tries <= '0;
    end else begin
      state <= next_state;
      if (reg_hit) begin
        setting <= reg_wdata_i;
      end
      if (fault_clear_i || (oc_rise && state == OCFR_RUN && tries == 3'h0)) begin
        tries <= '0;
      end else if (state == OCFR_START && next_state == OCFR_WAIT &&
                   retry != OCFR_RETRY_FOREVER) begin
        tries <= tries + 3'h1;
      end else if (state == OCFR_RUN && !oc && tries != 3'h0 &&
                   next_state == OCFR_RUN) begin
        tries <= '0;
      end
    end
  end

  // outputs and status
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      output_en_o <= 1'b0;
      current_limit_o <= 1'b0;
      oc_fault_status_o <= 1'b0;
      host_notify_o <= 1'b0;
      latched_off_o <= 1'b0;
      reg_rdata_o <= 8'h00;
    end else begin
      output_en_o <= next_state == OCFR_RUN || next_state == OCFR_LIMIT;
      current_limit_o <= next_state == OCFR_LIMIT;
      latched_off_o <= next_state == OCFR_LATCH;
      host_notify_o <= oc_rise;
      if (oc_rise) begin
        oc_fault_status_o <= 1'b1;
      end else if (fault_clear_i) begin
        oc_fault_status_o <= 1'b0;
      end
      reg_rdata_o <= (reg_addr_i == OCFR_REG_OFFSET) ? setting : 8'h00;
    end
  end

  a_status_set: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    oc_rise |=> oc_fault_status_o && host_notify_o)
    else $error("overcurrent did not set status");
  a_zero_latch: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    state == OCFR_START && retry == OCFR_RETRY_NONE |=> state == OCFR_LATCH)
    else $error("retry zero did not latch off");
  a_off_immed: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    state == OCFR_RUN && oc && resp == OCFR_RESP_OFF |=> !output_en_o)
    else $error("code 11 did not shut down");
  a_latch_hold: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    state == OCFR_LATCH && !fault_clear_i |=> state == OCFR_LATCH)
    else $error("latched off left without clear");
  a_ignore_limit: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    state == OCFR_LIMIT && resp == OCFR_RESP_IGNORE && oc |=>
    state == OCFR_LIMIT)
    else $error("code 00 left current limit");
  a_floor_trip: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    state == OCFR_LIMIT && oc && resp == OCFR_RESP_COND && lv |=>
    state == OCFR_START)
    else $error("low voltage did not shut down");
  a_forever_retry: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    state == OCFR_START && retry == OCFR_RETRY_FOREVER && !stop_all |=>
    state == OCFR_WAIT)
    else $error("continuous retry stopped");
  a_stop_retry: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    state == OCFR_WAIT && stop_all |=> state == OCFR_LATCH)
    else $error("retry not ended by stop condition");
  a_tries_spent: assert property (
    @(posedge clk_sys_i) disable iff (!nrst_i)
    state == OCFR_START && retry != OCFR_RETRY_FOREVER && tries >= retry |=>
    state == OCFR_LATCH)
    else $error("attempts spent but output not latched off");
endmodule : ocfr_fault_response

/* File: ocfr_stage_model.sv */
`timescale 1ns/100ps
// power stage model: a shorted load trips the threshold comparator
module ocfr_stage_model (
  input wire logic clk_sys_i,
  input wire logic overload_i,
  output logic oc_det_o
);
  // comparator output follows the load one cycle later
  always_ff @(posedge clk_sys_i) begin
    oc_det_o <= overload_i;
  end
endmodule : ocfr_stage_model

/* File: ocfr_fault_response_tb.sv */
`timescale 1ns/100ps
module ocfr_fault_response_tb;
  import ocfr_pkg::*;
  logic clk_sys_i = 0, nrst_i = 0, reg_wr_i = 0, lv_det_i = 0;
  logic bias_ok_i = 1, fault_clear_i = 0, overload = 0, en_d = 0;
  logic run_cmd_i = 1, other_fault_i = 0;
  logic [7:0] reg_addr_i = 8'h47, reg_wdata_i = 8'h00, reg_rdata_o;
  logic oc_det_i, output_en_o, current_limit_o, oc_fault_status_o;
  logic host_notify_o, latched_off_o;
  int err_count = 0, tests_run = 0, cyc = 0, rises = 0, pulses = 0, t0;
  // setting, floor flag, expected enable, expected limiting
  logic [10:0] rows [5] = '{11'h003, 11'h203, 11'h204, 11'h43b, 11'h600};
  ocfr_stage_model i_ocfr_stage_model (.clk_sys_i(clk_sys_i),
    .overload_i(overload), .oc_det_o(oc_det_i));
  ocfr_fault_response i_ocfr_fault_response (.clk_sys_i(clk_sys_i),
    .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .unit_cycles_i(16'h0004), .oc_det_i(oc_det_i), .lv_det_i(lv_det_i),
    .run_cmd_i(run_cmd_i), .bias_ok_i(bias_ok_i),
    .other_fault_i(other_fault_i),
    .fault_clear_i(fault_clear_i), .output_en_o(output_en_o),
    .current_limit_o(current_limit_o),
    .oc_fault_status_o(oc_fault_status_o), .host_notify_o(host_notify_o),
    .latched_off_o(latched_off_o));
  always #5 clk_sys_i = ~clk_sys_i;
  // cycle count, restart starts, notify pulses and hang guard
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    en_d <= output_en_o;
    if (output_en_o && !en_d) rises <= rises + 1;
    if (host_notify_o) pulses <= pulses + 1;
    if (cyc == 30000) begin
      err_count++;
      tally_and_finish();
    end
  end
  task tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task chk(input string n, input logic [7:0] s, input logic [7:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1;
    @(negedge clk_sys_i) reg_wr_i = 0;
    reg_addr_i = 8'h47;
  endtask : wr
  // remove the load, clear the fault and let the output come back
  task clr();
    overload = 0;
    lv_det_i = 0;
    bias_ok_i = 1;
    run_cmd_i = 1;
    other_fault_i = 0;
    repeat (4) @(negedge clk_sys_i);
    fault_clear_i = 1;
    @(negedge clk_sys_i) fault_clear_i = 0;
    repeat (6) @(negedge clk_sys_i);
    pulses = 0;
    rises = 0;
  endtask : clr
  // hold the overload until the output latches off, count restarts
  task retry(input logic [7:0] s, input logic [7:0] n);
    clr();
    wr(8'h47, s);
    overload = 1;
    for (int i = 0; i < 3000 && !latched_off_o; i++) @(negedge clk_sys_i);
    chk("restarts", rises[7:0], n);
    chk("latched", latched_off_o, 1);
  endtask : retry
  initial begin
    repeat (2) @(negedge clk_sys_i);
    chk("rst_en", output_en_o, 0);
    nrst_i = 1;
    repeat (4) @(negedge clk_sys_i);
    chk("rst_reg", reg_rdata_o, OCFR_REG_RESET);
    wr(8'h47, 8'ha5);
    @(negedge clk_sys_i) chk("reg_rd", reg_rdata_o, 8'ha5);
    wr(8'h48, 8'h5a);
    @(negedge clk_sys_i) chk("kept", reg_rdata_o, 8'ha5);
    reg_addr_i = 8'h48;
    @(negedge clk_sys_i) chk("unmapped", reg_rdata_o, 8'h00);
    foreach (rows[i]) begin
      clr();
      wr(8'h47, rows[i][10:3]);
      lv_det_i = rows[i][2];
      overload = 1;
      repeat (8) @(negedge clk_sys_i);
      chk("en", output_en_o, rows[i][1]);
      chk("limit", current_limit_o, rows[i][0]);
      chk("off", latched_off_o, !rows[i][1]);
      chk("status", oc_fault_status_o, 1);
      chk("notify", pulses[7:0], 1);
    end
    retry(8'h80, 0);
    retry(8'h88, 1);
    retry(8'hc8, 1);
    retry(8'hd0, 2);
    retry(8'hd0, 2);
    retry(8'hf0, 6);
    for (int d = 0; d < 3; d += 2) begin
      clr();
      wr(8'h47, 8'hc8 | 8'(d));
      overload = 1;
      while (output_en_o) @(negedge clk_sys_i);
      t0 = cyc;
      while (!output_en_o) @(negedge clk_sys_i);
      t0 = cyc - t0 - (4 << d);
      chk("gap", 8'(t0 >= 0 && t0 <= 3), 1);
    end
    // endless retry, ended by each stop condition in turn
    for (int k = 0; k < 3; k++) begin
      clr();
      wr(8'h47, 8'hf8);
      overload = 1;
      repeat (150) @(negedge clk_sys_i);
      chk("forever", 8'(latched_off_o || rises < 5), 0);
      if (k == 0) bias_ok_i = 0;
      else if (k == 1) run_cmd_i = 0;
      else other_fault_i = 1;
      repeat (40) @(negedge clk_sys_i);
      chk("stop_en", output_en_o, 0);
      chk("stop_off", latched_off_o, 1);
    end
    // reset in mid-run clears latch, status and setting
    nrst_i = 0;
    @(negedge clk_sys_i);
    chk("mid_off", latched_off_o, 0);
    chk("mid_status", oc_fault_status_o, 0);
    nrst_i = 1;
    @(negedge clk_sys_i);
    chk("mid_en", output_en_o, 1);
    chk("mid_reg", reg_rdata_o, OCFR_REG_RESET);
    tally_and_finish();
  end
endmodule : ocfr_fault_response_tb
